// *** rtl/octal_uart_tx_datapath.v ***
// Eight-channel UART data path: holding-register access, baud generation,
// transmit holding/shift path with empty flags, and per-channel FIFOs.
// Assumes a single-byte host access port on CLK_SYS_I and a receiver on the
// same clock that delivers bytes into the receive FIFO.
// Control bytes arrive and status bytes leave as plain per-channel ports; only the holding
// locations are decoded from the address, and the divisor also arrives on a per-channel port.
`timescale 1ns/1ns
`include "octal_uart_regs.vh"

// ****************************************************************
// Synchronous FIFO with valid/ready on both sides
// Depth need not be a power of two: pointers wrap on a compare against DEPTH-1
// ****************************************************************
module uart_byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 64,
  parameter AW = 6
) (
  input wire clk,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0] level
);
  // Storage, pointers and fill count
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  // Accepted push and pop of this cycle
  wire push;
  wire pop;

  // Handshakes and honest full/empty
  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];
  assign level = count_reg;

  // Storage write
  always @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill count
  always @(posedge clk) begin
    if (reset) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // uart_byte_fifo

// ****************************************************************
// Eight-channel transmit and baud data path
// ****************************************************************
module octal_uart_tx_datapath #(
  parameter CHANNELS = 8,
  parameter FIFO_DEPTH = 64,
  parameter FIFO_AW = 6
) (
  input wire CLK_SYS_I,
  input wire RESET_I,
  input wire [11:0] ADDR_I,
  input wire WR_I,
  input wire RD_I,
  input wire [7:0] WDATA_I,
  output reg [7:0] RDATA_O,
  output reg RD_VALID_O,
  input wire [CHANNELS*8-1:0] MCR_I,
  input wire [CHANNELS*8-1:0] FCR_I,
  input wire [CHANNELS*8-1:0] IER_I,
  input wire [CHANNELS*8-1:0] LCR_I,
  input wire [CHANNELS-1:0] EIGHT_X_I,
  input wire [CHANNELS*16-1:0] DIVISOR_I,
  input wire [CHANNELS*8-1:0] TX_TRIG_I,
  input wire [CHANNELS-1:0] RX_VALID_I,
  input wire [CHANNELS*8-1:0] RX_DATA_I,
  output wire [CHANNELS-1:0] RX_READY_O,
  output wire [CHANNELS-1:0] TX_READY_O,
  output wire [CHANNELS-1:0] SAMPLE_TICK_O,
  output wire [CHANNELS-1:0] TX_O,
  output wire [CHANNELS*8-1:0] LSR_O,
  output wire [CHANNELS*8-1:0] ISR_O
);
  // Transmit engine states
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_PARITY = 3'h3;
  localparam ST_STOP = 3'h4;
  localparam ST_STOP2 = 3'h5;

  // Per-channel vectors hold channel g in slice g
  wire [2:0] ch_sel;
  wire hold_hit;
  wire [CHANNELS*8-1:0] rx_head;
  wire [CHANNELS-1:0] rx_avail;

  // ****************************************************************
  // Holding-location decode and read answer
  // ****************************************************************
  // Holding location decode: channel in upper bits, zero offset inside
  assign ch_sel = ADDR_I[`CH_SEL_MSB:`CH_SEL_LSB];
  assign hold_hit = (ADDR_I[`IN_CH_MSB:0] == 9'h000);

  // Read answer: pop byte of the addressed channel one cycle later
  // Unmapped or empty reads answer zero so that no stale byte leaks out
  always @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      RDATA_O <= `RDATA_RESET;
      RD_VALID_O <= 1'b0;
    end else begin
      RD_VALID_O <= RD_I;
      if (RD_I && hold_hit && rx_avail[ch_sel]) begin
        RDATA_O <= rx_head[ch_sel*8 +: 8];
      end else begin
        RDATA_O <= `RDATA_RESET;
      end
    end
  end

  // ****************************************************************
  // Per-channel baud generator, FIFOs and transmitter
  // ****************************************************************
  // One copy of the whole path per channel
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : chan
      // Channel number as a 3-bit constant for the address compare
      localparam [2:0] CH_ID = g;
      // Configuration slices of this channel
      wire [7:0] modem_control_reg = MCR_I[g*8 +: 8];
      wire [7:0] lcr = LCR_I[g*8 +: 8];
      wire [15:0] divisor = DIVISOR_I[g*16 +: 16];
      wire fifo_mode = FCR_I[g*8 + `FCR_FIFO_EN_BIT];
      // Host strobes aimed at this channel's holding location
      wire wr_hit = WR_I && hold_hit && (ch_sel == CH_ID);
      wire rd_hit = RD_I && hold_hit && (ch_sel == CH_ID);
      // Counters, engine state and the non-FIFO holding stage
      reg [1:0] pre_reg;
      reg [15:0] brg_reg;
      reg [3:0] tick_reg;
      reg [2:0] st_reg;
      reg [7:0] shift_reg;
      reg [2:0] bitn_reg;
      reg par_reg;
      reg tx_reg;
      reg [7:0] thr_reg;
      reg thr_full_reg;
      // Strobes derived from the counters and the FIFOs
      wire pre_tick;
      wire samp;
      wire bit_end;
      wire [2:0] last_bit;
      wire src_valid;
      wire [7:0] src_data;
      wire load;
      wire txf_in_ready;
      wire txf_valid;
      wire [7:0] txf_data;
      wire [FIFO_AW:0] txf_level;
      wire thr_empty;
      wire tsr_empty;

      // Prescaler: divide by 4 when the modem-control bit is set, else by 1
      assign pre_tick = modem_control_reg[`MCR_PRESCALE_BIT] ? (pre_reg == `PRESCALE_LAST) : 1'b1;
      // Sampling tick after divisor prescaled clocks; a zero divisor stops it
      assign samp = pre_tick && (divisor != 16'h0000) &&
        (brg_reg == divisor - 16'h0001);
      // Bit time of 16 or 8 sampling ticks
      assign bit_end = samp && (tick_reg == (EIGHT_X_I[g] ? `BIT_LAST_8X : `BIT_LAST_16X));
      assign last_bit = `WLEN_BASE + {1'b0, lcr[`LCR_WLEN_MSB:`LCR_WLEN_LSB]};
      assign SAMPLE_TICK_O[g] = samp;

      // Prescaler and baud counters
      // Clearing at or above the divisor keeps a lowered divisor from wrapping
      always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
          pre_reg <= 2'h0;
          brg_reg <= 16'h0000;
        end else begin
          pre_reg <= modem_control_reg[`MCR_PRESCALE_BIT] ? pre_reg + 2'h1 : 2'h0;
          if (pre_tick) begin
            brg_reg <= (samp || brg_reg >= divisor) ? 16'h0000 : brg_reg + 16'h0001;
          end
        end
      end

      // Transmit FIFO between host writes and the shift engine
      // A write to a full FIFO is dropped; TX_READY_O warns the host
      uart_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) tx_fifo (
        .clk(CLK_SYS_I),
        .reset(RESET_I),
        .in_valid(wr_hit && fifo_mode),
        .in_ready(txf_in_ready),
        .in_data(WDATA_I),
        .out_valid(txf_valid),
        .out_ready(fifo_mode && load),
        .out_data(txf_data),
        .level(txf_level)
      );

      // Receive FIFO, drained by reads of the holding location
      // Reads of any other offset never pop it
      uart_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) rx_fifo (
        .clk(CLK_SYS_I),
        .reset(RESET_I),
        .in_valid(RX_VALID_I[g]),
        .in_ready(RX_READY_O[g]),
        .in_data(RX_DATA_I[g*8 +: 8]),
        .out_valid(rx_avail[g]),
        .out_ready(rd_hit),
        .out_data(rx_head[g*8 +: 8]),
        .level()
      );

      // Holding byte source: host register or FIFO head
      // The engine takes a new byte only while idle, never mid-frame
      assign src_valid = fifo_mode ? txf_valid : thr_full_reg;
      assign src_data = fifo_mode ? txf_data : thr_reg;
      assign load = (st_reg == ST_IDLE) && src_valid;
      assign TX_READY_O[g] = fifo_mode ? txf_in_ready : !thr_full_reg;

      // Non-FIFO holding register; a new write wins over the hand-off
      // A write while full replaces the waiting byte
      always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
          thr_reg <= 8'h00;
          thr_full_reg <= 1'b0;
        end else if (wr_hit && !fifo_mode) begin
          thr_reg <= WDATA_I;
          thr_full_reg <= 1'b1;
        end else if (load && !fifo_mode) begin
          thr_full_reg <= 1'b0;
        end
      end

      // Shift engine: start, data, parity, stop
      always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
          st_reg <= ST_IDLE;
          shift_reg <= 8'h00;
          bitn_reg <= 3'h0;
          tick_reg <= 4'h0;
          par_reg <= 1'b0;
          tx_reg <= 1'b1;
        end else begin
          // Tick counter within a bit restarts at every bit boundary
          if (st_reg == ST_IDLE || bit_end) begin
            tick_reg <= 4'h0;
          end else if (samp) begin
            tick_reg <= tick_reg + 4'h1;
          end
          case (st_reg)
            // Mark level until a byte is ready, then start bit
            ST_IDLE: begin
              tx_reg <= 1'b1;
              if (load) begin
                shift_reg <= src_data;
                bitn_reg <= 3'h0;
                par_reg <= !lcr[`LCR_PAR_EVEN_BIT];
                tx_reg <= 1'b0;
                st_reg <= ST_START;
              end
            end
            // Start bit, then the first data bit
            ST_START: begin
              if (bit_end) begin
                tx_reg <= shift_reg[0];
                st_reg <= ST_DATA;
              end
            end
            // Data bits, parity accumulated as they leave
            ST_DATA: begin
              if (bit_end) begin
                par_reg <= par_reg ^ shift_reg[0];
                shift_reg <= {1'b0, shift_reg[7:1]};
                bitn_reg <= bitn_reg + 3'h1;
                if (bitn_reg == last_bit) begin
                  if (lcr[`LCR_PAR_EN_BIT]) begin
                    tx_reg <= par_reg ^ shift_reg[0];
                    st_reg <= ST_PARITY;
                  end else begin
                    tx_reg <= 1'b1;
                    st_reg <= ST_STOP;
                  end
                end else begin
                  tx_reg <= shift_reg[1];
                end
              end
            end
            // Parity bit, then the first stop bit
            ST_PARITY: begin
              if (bit_end) begin
                tx_reg <= 1'b1;
                st_reg <= ST_STOP;
              end
            end
            // First stop bit
            ST_STOP: begin
              if (bit_end) begin
                st_reg <= lcr[`LCR_STOP2_BIT] ? ST_STOP2 : ST_IDLE;
              end
            end
            // Optional second stop bit
            ST_STOP2: begin
              if (bit_end) begin
                st_reg <= ST_IDLE;
              end
            end
            // Unused codes fall back to idle with the line at mark
            default: begin
              st_reg <= ST_IDLE;
              tx_reg <= 1'b1;
            end
          endcase
        end
      end

      // Status flags and transmit-empty interrupt
      // Transmitter empty needs the holding stage drained and the engine idle
      // The pin comes straight from a register so it never glitches
      assign thr_empty = fifo_mode ? !txf_valid : !thr_full_reg;
      assign tsr_empty = thr_empty && (st_reg == ST_IDLE);
      assign TX_O[g] = tx_reg;
      assign LSR_O[g*8 +: 8] = {1'b0, tsr_empty, thr_empty, 5'h00};
      assign ISR_O[g*8 +: 8] = {6'h00, IER_I[g*8 + `IER_TX_EMPTY_BIT] &&
        (fifo_mode ? ({1'b0, txf_level} < TX_TRIG_I[g*8 +: 8]) : thr_empty), 1'b0};
    end
  endgenerate
endmodule // octal_uart_tx_datapath

// *** rtl/octal_uart_regs.vh ***
// Constants of the eight-channel UART transmit, baud and holding-register path.
// Assumes inclusion by bare name from rtl/; definitions only.
`ifndef OCTAL_UART_REGS_VH
`define OCTAL_UART_REGS_VH

// ****************************************************************
// Holding-register map (byte addresses)
// ****************************************************************
`define CH_STRIDE 12'h200
`define HOLD_CH0_OFS 12'h000
`define HOLD_CH1_OFS 12'h200
`define HOLD_CH2_OFS 12'h400
`define HOLD_CH3_OFS 12'h600
`define HOLD_CH4_OFS 12'h800
`define HOLD_CH5_OFS 12'hA00
`define HOLD_CH6_OFS 12'hC00
`define HOLD_CH7_OFS 12'hE00
`define CH_SEL_MSB 11
`define CH_SEL_LSB 9
`define IN_CH_MSB 8

// ****************************************************************
// Field positions of the per-channel control and status bytes
// ****************************************************************
`define MCR_PRESCALE_BIT 7
`define FCR_FIFO_EN_BIT 0
`define IER_TX_EMPTY_BIT 1
`define ISR_TX_EMPTY_BIT 1
`define LSR_THR_EMPTY_BIT 5
`define LSR_TSR_EMPTY_BIT 6
`define LCR_WLEN_MSB 1
`define LCR_WLEN_LSB 0
`define LCR_STOP2_BIT 2
`define LCR_PAR_EN_BIT 3
`define LCR_PAR_EVEN_BIT 4

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define RDATA_RESET 8'h00
`define STATUS_RESET 8'h00
`define PRESCALE_LAST 2'h3
`define BIT_LAST_16X 4'hF
`define BIT_LAST_8X 4'h7
`define WLEN_BASE 3'h4

`endif

// *** sim/octal_uart_chk.sv ***
// Port checker for the eight-channel UART data path.
// Assumes the bench config: ch0 plain, divisor 3; ch2 FIFO, divisor 1 by 4.
`timescale 1ns/1ns
module octal_uart_chk #(
  parameter CHANNELS = 8
) (
  input wire CLK_SYS_I,
  input wire RESET_I,
  input wire [11:0] ADDR_I,
  input wire WR_I,
  input wire RD_I,
  input wire [7:0] RDATA_O,
  input wire RD_VALID_O,
  input wire [CHANNELS*8-1:0] FCR_I,
  input wire [CHANNELS*8-1:0] IER_I,
  input wire [CHANNELS-1:0] TX_READY_O,
  input wire [CHANNELS-1:0] SAMPLE_TICK_O,
  input wire [CHANNELS-1:0] TX_O,
  input wire [CHANNELS*8-1:0] LSR_O,
  input wire [CHANNELS*8-1:0] ISR_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);
  // Holding location selected
  wire hold_sel = ADDR_I[8:0] == 9'h000;
  rd_answer_a: assert property (RD_I && hold_sel |=> RD_VALID_O)
    else $error("read not answered");
  no_answer_a: assert property (!RD_I |=> !RD_VALID_O)
    else $error("read answer without read");
  unmapped_zero_a: assert property (RD_I && !hold_sel |=> RDATA_O == 8'h00)
    else $error("unmapped read gave data");
  hold_load_a: assert property (WR_I && ADDR_I == 12'h000 && !FCR_I[0] && LSR_O[6]
    |=> !LSR_O[5] ##1 LSR_O[5])
    else $error("holding empty flag wrong after write");
  fifo_busy_a: assert property (FCR_I[16] && WR_I && ADDR_I == 12'h400 && TX_READY_O[2]
    |=> !LSR_O[21])
    else $error("holding empty while fifo holds data");
  line_idle_a: assert property (LSR_O[6] |-> TX_O[0])
    else $error("line not at mark while idle");
  drained_a: assert property ($rose(LSR_O[6]) |-> $past(TX_O[0]) && LSR_O[5])
    else $error("transmitter empty too early");
  irq_gate_a: assert property (!IER_I[33] |-> !ISR_O[33])
    else $error("interrupt while disabled");
  irq_plain_a: assert property (!FCR_I[0] |-> ISR_O[1] == (IER_I[1] && LSR_O[5]))
    else $error("interrupt not following holding empty");
  tick_div_a: assert property (SAMPLE_TICK_O[0]
    |=> !SAMPLE_TICK_O[0] [*2] ##1 SAMPLE_TICK_O[0])
    else $error("tick spacing wrong for divisor");
  tick_pre_a: assert property (SAMPLE_TICK_O[2]
    |=> !SAMPLE_TICK_O[2] [*3] ##1 SAMPLE_TICK_O[2])
    else $error("tick spacing wrong for prescaler");
endmodule // octal_uart_chk
bind octal_uart_tx_datapath octal_uart_chk #(.CHANNELS(CHANNELS)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .RD_VALID_O(RD_VALID_O), .FCR_I(FCR_I), .IER_I(IER_I),
  .TX_READY_O(TX_READY_O), .SAMPLE_TICK_O(SAMPLE_TICK_O), .TX_O(TX_O),
  .LSR_O(LSR_O), .ISR_O(ISR_O));

// *** sim/serial_line_monitor.sv ***
// Far-end serial receiver: samples ten-bit frames mid-bit on sampling ticks.
// Assumes a combinational tick pulse and a line driven from a register.
`timescale 1ns/1ns
module serial_line_monitor (
  input wire clk_i,
  input wire tick_i,
  input wire line_i,
  input wire [4:0] tpb_i,
  output reg [9:0] frame_o,
  output reg [15:0] bit_clks_o,
  output reg [7:0] frames_o
);
  integer n;
  integer clks;
  // Wait for the given number of sampling ticks
  task wait_ticks(input integer cnt);
    integer t;
    begin
      for (t = 0; t < cnt; t = t + 1) begin
        do begin
          @(negedge clk_i);
          clks = clks + 1;
        end while (tick_i !== 1'b1);
      end
    end
  endtask
  // Frame capture, start bit first, one bit time timed in clocks
  initial begin
    frame_o = 10'h000;
    bit_clks_o = 16'h0000;
    frames_o = 8'h00;
    forever begin
      @(negedge clk_i);
      if (line_i === 1'b0) begin
        clks = 0;
        wait_ticks(tpb_i / 2);
        frame_o[0] = line_i;
        for (n = 1; n < 10; n = n + 1) begin
          if (n == 2) clks = 0;
          wait_ticks(tpb_i);
          if (n == 2) bit_clks_o = clks[15:0];
          frame_o[n] = line_i;
        end
        frames_o = frames_o + 8'h01;
      end
    end
  end
endmodule // serial_line_monitor

// *** sim/octal_uart_tx_baud_datapath_tb.sv ***
// Testbench for the eight-channel UART data path, byte access tasks.
// Assumes the monitor model and the bound port checker.
`timescale 1ns/1ns
module octal_uart_tx_baud_datapath_tb;
  reg CLK_SYS_I, RESET_I, WR_I, RD_I;
  reg [11:0] ADDR_I;
  reg [7:0] WDATA_I, EIGHT_X_I, RX_VALID_I, b, c2;
  reg [63:0] MCR_I, FCR_I, IER_I, LCR_I, TX_TRIG_I, RX_DATA_I;
  reg [127:0] DIVISOR_I;
  wire [7:0] RDATA_O, RX_READY_O, TX_READY_O, SAMPLE_TICK_O, TX_O, cnt0, cnt2;
  wire RD_VALID_O;
  wire [63:0] LSR_O, ISR_O;
  wire [9:0] frame0, frame2;
  wire [15:0] clks0, clks2;
  integer errors, samples_checked, g, n;
  octal_uart_tx_datapath #(.CHANNELS(8), .FIFO_DEPTH(16), .FIFO_AW(4)) u_dut (
    .CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
    .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .RD_VALID_O(RD_VALID_O), .MCR_I(MCR_I),
    .FCR_I(FCR_I), .IER_I(IER_I), .LCR_I(LCR_I), .EIGHT_X_I(EIGHT_X_I),
    .DIVISOR_I(DIVISOR_I), .TX_TRIG_I(TX_TRIG_I), .RX_VALID_I(RX_VALID_I),
    .RX_DATA_I(RX_DATA_I), .RX_READY_O(RX_READY_O), .TX_READY_O(TX_READY_O),
    .SAMPLE_TICK_O(SAMPLE_TICK_O), .TX_O(TX_O), .LSR_O(LSR_O), .ISR_O(ISR_O));
  serial_line_monitor u_mon0 (.clk_i(CLK_SYS_I), .tick_i(SAMPLE_TICK_O[0]), .line_i(TX_O[0]),
    .tpb_i(5'h10), .frame_o(frame0), .bit_clks_o(clks0), .frames_o(cnt0));
  serial_line_monitor u_mon2 (.clk_i(CLK_SYS_I), .tick_i(SAMPLE_TICK_O[2]), .line_i(TX_O[2]),
    .tpb_i(5'h08), .frame_o(frame2), .bit_clks_o(clks2), .frames_o(cnt2));
  // 10 MHz clock
  always #50 CLK_SYS_I = ~CLK_SYS_I;
  task clk(input integer k);
    begin
      repeat (k) @(posedge CLK_SYS_I);
      #10;
    end
  endtask
  task chk(input string what, input [15:0] exp, input [15:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("mismatch %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Byte write; strobe stays up for back-to-back use
  task wr(input [11:0] a, input [7:0] d);
    begin
      ADDR_I = a;
      WDATA_I = d;
      WR_I = 1'b1;
      clk(1);
    end
  endtask
  task rd(input [11:0] a, input [7:0] exp);
    begin
      ADDR_I = a;
      RD_I = 1'b1;
      clk(1);
      RD_I = 1'b0;
      chk("read valid", 16'h0001, RD_VALID_O);
      chk("read data", exp, RDATA_O);
      clk(1);
    end
  endtask
  task wait_all;
    begin
      n = 0;
      while ((LSR_O & {8{8'h40}}) !== {8{8'h40}} && n < 20000) begin
        clk(1);
        n = n + 1;
      end
      chk("drain limit", 16'h0001, n < 20000);
    end
  endtask
  task results;
    begin
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    CLK_SYS_I = 1'b0; RESET_I = 1'b1; WR_I = 1'b0; RD_I = 1'b0; ADDR_I = 12'h000;
    WDATA_I = 8'h00; RX_VALID_I = 8'h00; RX_DATA_I = 64'h0; MCR_I = 64'h0; FCR_I = 64'h0;
    IER_I = 64'h0; TX_TRIG_I = 64'h0; EIGHT_X_I = 8'h04; errors = 0; samples_checked = 0;
    for (g = 0; g < 8; g = g + 1) begin
      LCR_I[g*8+:8] = 8'h03;
      DIVISOR_I[g*16+:16] = 16'h0003;
    end
    IER_I[7:0] = 8'h02; FCR_I[23:16] = 8'h01; IER_I[23:16] = 8'h02; TX_TRIG_I[23:16] = 8'h02;
    MCR_I[23:16] = 8'h80; LCR_I[23:16] = 8'h1A; DIVISOR_I[47:32] = 16'h0001;
    FCR_I[39:32] = 8'h01; TX_TRIG_I[39:32] = 8'h02;
    clk(5);
    RESET_I = 1'b0;
    chk("line idle", 16'h00FF, TX_O);
    for (g = 0; g < 8; g = g + 1) begin
      chk("status", 16'h0060, LSR_O[g*8+:8]);
      b = {6'h00, IER_I[g*8+1] & (FCR_I[g*8] ? TX_TRIG_I[g*8+:8] != 8'h00 : 1'b1), 1'b0};
      chk("irq", b, ISR_O[g*8+:8]);
    end
    wr(12'h000, 8'hA5);
    WR_I = 1'b0;
    chk("hold full", 16'h0000, {LSR_O[5], TX_READY_O[0]});
    clk(1);
    chk("hold moved", 16'h0002, {LSR_O[6], LSR_O[5], TX_O[0]});
    wait_all;
    chk("frame ch0", {6'h00, 1'b1, 8'hA5, 1'b0}, frame0);
    chk("bit clocks ch0", 16'h0030, clks0);
    for (g = 0; g < 8; g = g + 1) begin
      wr({g[2:0], 9'h000}, g[7:0]);
      WR_I = 1'b0;
      for (n = 0; n < 8; n = n + 1) b[n] = LSR_O[n*8+5];
      chk("hold map", 8'hFF ^ (8'h01 << g), b);
      clk(1);
    end
    wait_all;
    chk("frame ch2", {6'h00, 1'b1, 1'b1, 7'h02, 1'b0}, frame2);
    chk("bit clocks ch2", 16'h0020, clks2);
    RX_DATA_I[31:24] = 8'h3C;
    RX_VALID_I[3] = 1'b1;
    chk("rx ready", 16'h0001, RX_READY_O[3]);
    clk(1);
    RX_DATA_I[31:24] = 8'hC3;
    clk(1);
    RX_VALID_I[3] = 1'b0;
    rd(12'h601, 8'h00);
    rd(12'h600, 8'h3C);
    rd(12'h600, 8'hC3);
    rd(12'h600, 8'h00);
    // Six data bits, odd parity, two stop bits on channel 0
    LCR_I[7:0] = 8'h0D;
    wr(12'h000, 8'h2B);
    WR_I = 1'b0;
    wait_all;
    chk("frame odd", {6'h00, 1'b1, 1'b1, ~^6'h2B, 6'h2B, 1'b0}, frame0);
    c2 = cnt2;
    n = 0;
    while (TX_READY_O[2] === 1'b1 && n < 40) begin
      wr(12'h400, n[7:0]);
      n = n + 1;
    end
    wr(12'h400, 8'h6E);
    WR_I = 1'b0;
    g = n;
    chk("fill depth", 16'h0001, g >= 16 && g <= 18);
    chk("fill status", 16'h0000, {LSR_O[21], ISR_O[17]});
    wait_all;
    b = g - 1;
    chk("fifo frames", g, cnt2 - c2);
    chk("fifo last", {6'h00, 1'b1, ^b[6:0], b[6:0], 1'b0}, frame2);
    chk("drained", 16'h0003, {LSR_O[21], ISR_O[17]});
    // Reset in mid-run while channel 2 holds and sends data
    wr(12'h400, 8'h11);
    wr(12'h400, 8'h22);
    WR_I = 1'b0;
    RESET_I = 1'b1;
    clk(1);
    RESET_I = 1'b0;
    chk("reset line", 16'h00FF, TX_O);
    chk("reset status", 16'h0060, LSR_O[23:16]);
    chk("reset irq", 16'h0002, ISR_O[23:16]);
    results;
  end
  // Hang guard
  initial begin
    #(100 * 60000);
    errors = errors + 1;
    results;
  end
endmodule // octal_uart_tx_baud_datapath_tb
